// ---- verilog/counter_pkg.sv ----
package counter_pkg;

   // ==========================================================
   // Counter
   localparam int CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_MAX = 4'hf;

   // ==========================================================
   // Pins sampled through the three-stage filter
   typedef struct packed {
      logic clkPin;
      logic loadN;
      logic countEn;
      logic carryEn;
      logic [3:0] preset;
   } pin_t;
   localparam int PIN_W = 8;
   localparam pin_t PIN_RESET = '{clkPin: 1'b0, loadN: 1'b1, countEn: 1'b0, carryEn: 1'b0, preset: 4'h0};

   // ==========================================================
   // Software control word, bit 0 upward: mode, count enable, carry enable, load (low active)
   typedef struct packed {
      logic swLoadN;
      logic swCarryEn;
      logic swCountEn;
      logic swMode;
   } ctrl_t;
   localparam int CTRL_W = 4;
   localparam ctrl_t CTRL_RESET = '{swLoadN: 1'b1, swCarryEn: 1'b0, swCountEn: 1'b0, swMode: 1'b0};

   // ==========================================================
   // Register map, byte addresses
   localparam int AXI_AW = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_PRESET = 4'h4;
   localparam logic [3:0] REG_STEP = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int ST_CARRY = 4;
   localparam int ST_GATE = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0;

   typedef enum logic [0:0] {
      WR_IDLE = 1'b0,
      WR_RESP = 1'b1
   } wr_state_t;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } rd_state_t;

endpackage

// ---- verilog/sync_counter.sv ----
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Apart from clear, counter state changes only on a rising edge of the counting clock.
// - All four count bits update together in one register, no ripple.
// - Clear low forces count to zero at once, overriding everything else.
// - Load low at a rising edge copies preset data, whatever the enables.
// - Any preset value from 0 to 15 is accepted.
// - Count advances by one only when both enables are high; else holds.
// - Plain binary counting, wrapping from 15 to 0.
// - Carry output is high exactly while the count is 15 and carry enable is high.
// - Carry output is gated by the carry enable alone.
// - Load and enable changes affect the count only at the next rising clock edge.
// - Enable transitions at any clock level never corrupt the count.
module sync_counter (
   input wire logic clk_sys, // System clock, 250 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic counterClk, // Counting clock pin
   input wire logic async_clear_n, // Async clear pin, active low
   input wire logic parallelLoadN, // Synchronous load pin, active low
   input wire logic count_gate_enable, // Count enable pin
   input wire logic carry_gate_enable, // Count and carry enable pin
   input wire logic [3:0] presetData, // Preset data, bit 0 least significant
   output logic count_out_bit0, // Count bit 0
   output logic count_out_bit1, // Count bit 1
   output logic count_out_bit2, // Count bit 2
   output logic count_out_bit3, // Count bit 3
   output logic terminal_carry_out, // High at terminal count when gated
   input wire logic [3:0] awaddr, // AXI write address
   input wire logic awvalid, // AXI write address valid
   output logic awready, // AXI write address ready
   input wire logic [31:0] wdata, // AXI write data
   input wire logic [3:0] wstrb, // AXI write strobes
   input wire logic wvalid, // AXI write data valid
   output logic wready, // AXI write data ready
   output logic [1:0] bresp, // AXI write response
   output logic bvalid, // AXI write response valid
   input wire logic bready, // AXI write response ready
   input wire logic [3:0] araddr, // AXI read address
   input wire logic arvalid, // AXI read address valid
   output logic arready, // AXI read address ready
   output logic [31:0] rdata, // AXI read data
   output logic [1:0] rresp, // AXI read response
   output logic rvalid, // AXI read data valid
   input wire logic rready // AXI read data ready
);

   // ==========================================================
   // Pin filter
   // Data pins share the clock pin's delay, so levels line up with the edge
   // Bits whose stages disagree keep their last filtered level
   counter_pkg::pin_t pinNow;
   logic [counter_pkg::PIN_W-1:0] s1Q, s2Q, s3Q, fQ, fD, agree;
   counter_pkg::pin_t pinF, pinFQ;

   assign pinNow = '{clkPin: counterClk, loadN: parallelLoadN, countEn: count_gate_enable,
                     carryEn: carry_gate_enable, preset: presetData};

   always_comb begin
      agree = ~(s2Q ^ s3Q);
      fD = (s3Q & agree) | (fQ & ~agree);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1Q <= counter_pkg::PIN_RESET;
         s2Q <= counter_pkg::PIN_RESET;
         s3Q <= counter_pkg::PIN_RESET;
         fQ <= counter_pkg::PIN_RESET;
      end else begin
         s1Q <= pinNow;
         s2Q <= s1Q;
         s3Q <= s2Q;
         fQ <= fD;
      end
   end

   assign pinF = counter_pkg::pin_t'(fD);
   assign pinFQ = counter_pkg::pin_t'(fQ);

   // ==========================================================
   // Register bus: write side
   counter_pkg::wr_state_t wrStateQ, wrStateD;
   counter_pkg::ctrl_t ctrlQ, ctrlD;
   logic [3:0] presetRegQ, presetRegD;
   logic awHaveQ, awHaveD, wHaveQ, wHaveD;
   logic [3:0] wAddrQ, wAddrD;
   logic [31:0] wDataQ, wDataD;
   logic [3:0] wStrbQ, wStrbD;
   logic awreadyD, wreadyD, bvalidD;
   logic [1:0] brespD;
   logic stepPulse;

   always_comb begin
      wrStateD = wrStateQ;
      ctrlD = ctrlQ;
      presetRegD = presetRegQ;
      awHaveD = awHaveQ | (awvalid & awready);
      wHaveD = wHaveQ | (wvalid & wready);
      wAddrD = (awvalid & awready) ? awaddr : wAddrQ;
      wDataD = (wvalid & wready) ? wdata : wDataQ;
      wStrbD = (wvalid & wready) ? wstrb : wStrbQ;
      bvalidD = bvalid;
      brespD = bresp;
      stepPulse = 1'b0;
      case (wrStateQ)
         counter_pkg::WR_IDLE: begin
            if (awHaveD && wHaveD) begin
               awHaveD = 1'b0;
               wHaveD = 1'b0;
               bvalidD = 1'b1;
               brespD = counter_pkg::RESP_OKAY;
               wrStateD = counter_pkg::WR_RESP;
               case (wAddrD)
                  counter_pkg::REG_CTRL: begin
                     if (wStrbD[0]) begin
                        ctrlD = counter_pkg::ctrl_t'(wDataD[counter_pkg::CTRL_W-1:0]);
                     end
                  end
                  counter_pkg::REG_PRESET: begin
                     if (wStrbD[0]) begin
                        presetRegD = wDataD[counter_pkg::CNT_W-1:0];
                     end
                  end
                  counter_pkg::REG_STEP: begin
                     // Counting edge in software mode
                     stepPulse = 1'b1;
                  end
                  counter_pkg::REG_STATUS: begin
                     brespD = counter_pkg::RESP_OKAY;
                  end
                  default: begin
                     brespD = counter_pkg::RESP_SLVERR;
                  end
               endcase
            end
         end
         counter_pkg::WR_RESP: begin
            if (bready) begin
               bvalidD = 1'b0;
               wrStateD = counter_pkg::WR_IDLE;
            end
         end
         default: begin
            wrStateD = counter_pkg::WR_IDLE;
         end
      endcase
      awreadyD = (wrStateD == counter_pkg::WR_IDLE) && !awHaveD;
      wreadyD = (wrStateD == counter_pkg::WR_IDLE) && !wHaveD;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wrStateQ <= counter_pkg::WR_IDLE;
         ctrlQ <= counter_pkg::CTRL_RESET;
         presetRegQ <= counter_pkg::CNT_ZERO;
         awHaveQ <= 1'b0;
         wHaveQ <= 1'b0;
         wAddrQ <= 4'h0;
         wDataQ <= 32'h0;
         wStrbQ <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= counter_pkg::RESP_OKAY;
      end else begin
         wrStateQ <= wrStateD;
         ctrlQ <= ctrlD;
         presetRegQ <= presetRegD;
         awHaveQ <= awHaveD;
         wHaveQ <= wHaveD;
         wAddrQ <= wAddrD;
         wDataQ <= wDataD;
         wStrbQ <= wStrbD;
         awready <= awreadyD;
         wready <= wreadyD;
         bvalid <= bvalidD;
         bresp <= brespD;
      end
   end

   // ==========================================================
   // Counter core
   logic opEdge, opLoadN, opCountEn, opCarryEn;
   logic [3:0] opPreset;
   logic [3:0] countQ, countD;
   logic carryQ, carryD, gateQ;
   logic clearAllN;

   // Pin mode lags the pin by four clocks, the price of filtering
   always_comb begin
      if (ctrlQ.swMode) begin
         opEdge = stepPulse;
         opLoadN = ctrlQ.swLoadN;
         opCountEn = ctrlQ.swCountEn;
         opCarryEn = ctrlQ.swCarryEn;
         opPreset = presetRegQ;
      end else begin
         opEdge = pinF.clkPin && !pinFQ.clkPin;
         opLoadN = pinF.loadN;
         opCountEn = pinF.countEn;
         opCarryEn = pinF.carryEn;
         opPreset = pinF.preset;
      end
      countD = countQ;
      if (opEdge) begin
         if (!opLoadN) begin
            countD = opPreset;
         end else if (opCountEn && opCarryEn) begin
            countD = countQ + counter_pkg::CNT_ONE;
         end
      end
      carryD = (countD == counter_pkg::CNT_MAX) && opCarryEn;
   end

   // Clear pin acts without the clock; a glitch on it clears too, by design
   assign clearAllN = rstn & async_clear_n;

   always_ff @(posedge clk_sys or negedge clearAllN) begin
      if (!clearAllN) begin
         countQ <= counter_pkg::CNT_ZERO;
         carryQ <= 1'b0;
         gateQ <= 1'b0;
      end else begin
         countQ <= countD;
         carryQ <= carryD;
         gateQ <= opCarryEn;
      end
   end

   assign count_out_bit0 = countQ[0];
   assign count_out_bit1 = countQ[1];
   assign count_out_bit2 = countQ[2];
   assign count_out_bit3 = countQ[3];
   assign terminal_carry_out = carryQ;

   // ==========================================================
   // Register bus: read side
   counter_pkg::rd_state_t rdStateQ, rdStateD;
   logic arreadyD, rvalidD;
   logic [31:0] rdataD;
   logic [1:0] rrespD;

   always_comb begin
      rdStateD = rdStateQ;
      rvalidD = rvalid;
      rdataD = rdata;
      rrespD = rresp;
      case (rdStateQ)
         counter_pkg::RD_IDLE: begin
            if (arvalid && arready) begin
               rvalidD = 1'b1;
               rdStateD = counter_pkg::RD_DATA;
               rdataD = counter_pkg::RDATA_ZERO;
               rrespD = counter_pkg::RESP_OKAY;
               case (araddr)
                  counter_pkg::REG_CTRL: rdataD[counter_pkg::CTRL_W-1:0] = ctrlQ;
                  counter_pkg::REG_PRESET: rdataD[counter_pkg::CNT_W-1:0] = presetRegQ;
                  counter_pkg::REG_STEP: rdataD = counter_pkg::RDATA_ZERO;
                  counter_pkg::REG_STATUS: begin
                     rdataD[counter_pkg::CNT_W-1:0] = countQ;
                     rdataD[counter_pkg::ST_CARRY] = carryQ;
                     rdataD[counter_pkg::ST_GATE] = gateQ;
                  end
                  default: rrespD = counter_pkg::RESP_SLVERR;
               endcase
            end
         end
         counter_pkg::RD_DATA: begin
            if (rready) begin
               rvalidD = 1'b0;
               rdStateD = counter_pkg::RD_IDLE;
            end
         end
         default: begin
            rdStateD = counter_pkg::RD_IDLE;
         end
      endcase
      arreadyD = (rdStateD == counter_pkg::RD_IDLE);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdStateQ <= counter_pkg::RD_IDLE;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= counter_pkg::RDATA_ZERO;
         rresp <= counter_pkg::RESP_OKAY;
      end else begin
         rdStateQ <= rdStateD;
         arready <= arreadyD;
         rvalid <= rvalidD;
         rdata <= rdataD;
         rresp <= rrespD;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!clearAllN);

   a_load_copies: assert property ((opEdge && !opLoadN) |=> countQ == $past(opPreset))
      else $error("load did not copy preset");
   a_count_step: assert property ((opEdge && opLoadN && opCountEn && opCarryEn)
      |=> countQ == 4'($past(countQ) + counter_pkg::CNT_ONE))
      else $error("count did not advance by one");
   a_wrap_zero: assert property ((opEdge && opLoadN && opCountEn && opCarryEn && countQ == counter_pkg::CNT_MAX)
      |=> countQ == counter_pkg::CNT_ZERO)
      else $error("count did not wrap to zero");
   a_hold_noedge: assert property (!opEdge |=> $stable(countQ))
      else $error("count moved without an edge");
   a_enable_hold: assert property ((opEdge && opLoadN && !(opCountEn && opCarryEn)) |=> $stable(countQ))
      else $error("count moved while disabled");
   a_carry_term: assert property ((countQ == counter_pkg::CNT_MAX && gateQ) iff terminal_carry_out)
      else $error("carry does not follow terminal count");
   a_carry_gated: assert property (!opCarryEn |=> !terminal_carry_out)
      else $error("carry high while gate low");
   a_clear_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      !async_clear_n |-> countQ == counter_pkg::CNT_ZERO && !terminal_carry_out)
      else $error("clear did not force zero");
   a_bus_resp: assert property ((wrStateQ == counter_pkg::WR_IDLE && (awHaveQ || (awvalid && awready))
      && (wHaveQ || (wvalid && wready))) |=> bvalid)
      else $error("write response missing");
   a_rdata_hold: assert property ((rvalid && !rready) |=> rvalid && $stable(rdata))
      else $error("read data dropped before taken");
   a_read_resp: assert property ((rdStateQ == counter_pkg::RD_IDLE && arvalid && arready) |=> rvalid)
      else $error("read response missing");
   a_write_single: assert property (bvalid |-> !awready && !wready)
      else $error("new write accepted during response");
   a_filter_agree: assert property ((s2Q == s3Q) |=> fQ == $past(s3Q))
      else $error("filter ignored agreeing stages");
   a_carry_low: assert property ((countQ != counter_pkg::CNT_MAX) |-> !terminal_carry_out)
      else $error("carry high away from terminal count");

   c_load: cover property (opEdge && !opLoadN);
   c_wrap: cover property (countQ == counter_pkg::CNT_MAX ##1 countQ == counter_pkg::CNT_ZERO);
   c_carry: cover property (terminal_carry_out);
   c_step: cover property (stepPulse && ctrlQ.swMode);
   c_clear: cover property (@(posedge clk_sys) disable iff (!rstn) !async_clear_n && countQ == counter_pkg::CNT_ZERO);

endmodule

// ---- tb/cascade_partner.sv ----
`timescale 1ns/1ps
// ==========================================
// Counting clock source and upper cascaded stage
module cascade_partner (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Reset, active low
   input wire logic pulseReq, // Request one counting pulse
   input wire logic carryIn, // Carry from lower stage
   output logic counterClk, // Counting clock
   output logic busy, // Pulse in progress
   output logic [3:0] upperCount // Upper stage count
);
   logic [3:0] phase_q;
   // High 4, low 5 cycles, beyond the filter's 2-cycle minimum
   assign counterClk = (phase_q != 4'h0) && (phase_q < 4'h5);
   assign busy = (phase_q != 4'h0);
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase_q <= 4'h0;
         upperCount <= 4'h0;
      end else if (phase_q == 4'h0) begin
         if (pulseReq) begin
            phase_q <= 4'h1;
            // Same clock edge, lower carry enables this stage
            if (carryIn) begin
               upperCount <= upperCount + 4'h1;
            end
         end
      end else begin
         phase_q <= (phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
      end
   end
endmodule

// ---- tb/four_bit_sync_counter_tb.sv ----
`timescale 1ns/1ps
module four_bit_sync_counter_tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic async_clear_n = 1'b1;
   logic parallelLoadN = 1'b1;
   logic count_gate_enable = 1'b0;
   logic carry_gate_enable = 1'b0;
   logic [3:0] presetData = 4'h0;
   logic pulseReq = 1'b0;
   logic counterClk, busy, b0, b1, b2, b3, terminal_carry_out;
   logic [3:0] upperCount, cnt;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;

   always #2 clk_sys = ~clk_sys;
   assign cnt = {b3, b2, b1, b0};

   sync_counter u_dut (.clk_sys(clk_sys), .rstn(rstn), .counterClk(counterClk), .async_clear_n(async_clear_n),
      .parallelLoadN(parallelLoadN), .count_gate_enable(count_gate_enable), .carry_gate_enable(carry_gate_enable),
      .presetData(presetData), .count_out_bit0(b0), .count_out_bit1(b1), .count_out_bit2(b2),
      .count_out_bit3(b3), .terminal_carry_out(terminal_carry_out), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   cascade_partner u_partner (.clk_sys(clk_sys), .rstn(rstn), .pulseReq(pulseReq),
      .carryIn(terminal_carry_out), .counterClk(counterClk), .busy(busy), .upperCount(upperCount));

   // ==========================================
   // Checking and closing
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Whole run needs a few hundred cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("timeout");
         tally_and_finish();
      end
   end

   // ==========================================
   // Register bus and pin drivers
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = counter_pkg::RESP_OKAY);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            check("bresp", bresp, er);
            break;
         end
      end
   endtask

   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er = counter_pkg::RESP_OKAY);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            check("rdata", rdata, ed);
            check("rresp", rresp, er);
            break;
         end
      end
   endtask

   // Levels settle well past the filter before any counting edge
   task automatic set_pins(input logic ld, input logic en, input logic ce, input logic [3:0] pre);
      @(posedge clk_sys);
      parallelLoadN <= ld;
      count_gate_enable <= en;
      carry_gate_enable <= ce;
      presetData <= pre;
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic pulse();
      @(posedge clk_sys);
      pulseReq <= 1'b1;
      @(posedge clk_sys);
      pulseReq <= 1'b0;
      @(posedge clk_sys);
      while (busy === 1'b1) @(posedge clk_sys);
   endtask

   // ==========================================
   // Tests
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      axi_read(counter_pkg::REG_CTRL, 32'h8);
      axi_read(counter_pkg::REG_PRESET, 32'h0);
      axi_read(counter_pkg::REG_STATUS, 32'h0);
      $display("test reset done");
      set_pins(1'b0, 1'b0, 1'b0, 4'hc);
      pulse();
      check("count", cnt, 4'hc);
      set_pins(1'b1, 1'b1, 1'b1, 4'h0);
      for (int i = 13; i < 16; i++) begin
         pulse();
         check("count", cnt, i[3:0]);
         check("carry", terminal_carry_out, i == 15);
      end
      set_pins(1'b1, 1'b1, 1'b0, 4'h0);
      check("carry", terminal_carry_out, 1'b0);
      pulse();
      check("count", cnt, 4'hf);
      set_pins(1'b1, 1'b0, 1'b1, 4'h0);
      check("carry", terminal_carry_out, 1'b1);
      pulse();
      check("count", cnt, 4'hf);
      set_pins(1'b1, 1'b1, 1'b1, 4'h0);
      pulse();
      check("count", cnt, 4'h0);
      // Carry stood high for this pulse and the held one before it
      check("upper", upperCount, 4'h2);
      set_pins(1'b0, 1'b0, 1'b0, 4'h5);
      check("count", cnt, 4'h0);
      pulse();
      check("count", cnt, 4'h5);
      @(posedge clk_sys);
      async_clear_n <= 1'b0;
      #1;
      check("count", cnt, 4'h0);
      pulse();
      check("count", cnt, 4'h0);
      @(posedge clk_sys);
      async_clear_n <= 1'b1;
      $display("test pins done");
      // Software mode, load low, enables off
      axi_write(counter_pkg::REG_CTRL, 32'h1);
      for (int v = 0; v < 16; v++) begin
         axi_write(counter_pkg::REG_PRESET, v);
         axi_write(counter_pkg::REG_STEP, 32'h0);
         axi_read(counter_pkg::REG_STATUS, v);
      end
      axi_write(counter_pkg::REG_CTRL, 32'hb);
      axi_read(counter_pkg::REG_STATUS, 32'hf);
      axi_write(counter_pkg::REG_STEP, 32'h0);
      axi_read(counter_pkg::REG_STATUS, 32'hf);
      axi_write(counter_pkg::REG_CTRL, 32'hf);
      axi_read(counter_pkg::REG_STATUS, 32'h3f);
      axi_write(counter_pkg::REG_STEP, 32'h0);
      axi_read(counter_pkg::REG_STATUS, 32'h20);
      axi_write(4'h6, 32'hf, counter_pkg::RESP_SLVERR);
      axi_read(4'h6, 32'h0, counter_pkg::RESP_SLVERR);
      axi_write(counter_pkg::REG_STATUS, 32'hff);
      axi_read(counter_pkg::REG_STATUS, 32'h20);
      axi_read(counter_pkg::REG_STEP, 32'h0);
      axi_read(counter_pkg::REG_PRESET, 32'hf);
      // Low strobe leaves the preset untouched
      wstrb <= 4'h0;
      axi_write(counter_pkg::REG_PRESET, 32'h3);
      wstrb <= 4'hf;
      axi_read(counter_pkg::REG_PRESET, 32'hf);
      $display("test software done");
      tally_and_finish();
   end
endmodule
